// ==== rtl/tape_ctrl_sense_error_logic.sv ====
// Sense and error logic of a tape controller, with an AXI4-Lite register slave.
// Assumes command, drive and datapath inputs come from logic on clk.
// Function
// - Report unit check whenever any first sense byte bit is set.
// - Reject write, tape mark or erase gap to a file protected drive.
// - Reject any command code outside the command set.
// - Reject security erase unless chained directly from erase gap.
// - Reject controller reserve/release without dual channel option or when chained.
// - Reject drive reserve, release, unconditional reserve unless first in chain.
// - In compatibility mode reject reserve, release, unconditional reserve, device type.
// - Intervention required on offline, absent, or drive going not ready.
// - Parity check on bad command or data byte; temp fault sets microprogram error.
// - Equipment check on erase noise, microprogram, reject drive, mark, write alarm.
// - Equipment check on tag, block, velocity, overrun, position, parity, gap flags.
// - Equipment check when block begin is missed during the amplification burst.
// - Data check on non erase noise or parity, track, skew, CRC, envelope, compare.
// - Data check on trigger parity, start read, partial, postamble, count overflow.
// - Data check on gap, readback timing, amplification, velocity, buffer, CRC flags.
// - Overrun when service is late; hidden whenever data check is set.
// - On overrun stop data transfer but let the tape operation finish.
// - No-data flag when write or loopback ends before the first byte.
// - Data converter bit of the first sense byte always reads zero.
// - Noise on data check during reads at the two higher densities.
// - Low density noise on noise block or data in stop delay.
// - Noise on any data seen during an erase portion.
// - Two drive status bits encode absent, powered offline, and ready.
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module tape_ctrl_sense_error_logic
	import tape_sense_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [tape_sense_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tape_sense_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_chained,
	input wire logic cmd_parity_err,
	input wire logic data_parity_err,
	input wire logic temp_hw_fault,
	input wire logic drive_present,
	input wire logic drive_powered,
	input wire logic drive_online,
	input wire logic drive_ready,
	input wire logic drive_file_protect,
	input wire logic op_active,
	input wire logic op_read,
	input wire logic op_write,
	input wire logic op_loopback,
	input wire logic op_erase,
	input wire logic [1:0] density,
	input wire logic at_load_point,
	input wire logic noise_block_detect,
	input wire logic stop_delay_data,
	input wire logic erase_data_detect,
	input wire logic [tape_sense_pkg::EQ_W-1:0] eq_detail_in,
	input wire logic [tape_sense_pkg::DCK_W-1:0] dck_detail_in,
	input wire logic ibg_detect,
	input wire logic auto_read_amp_burst,
	input wire logic block_begin_detect,
	input wire logic service_late,
	input wire logic xfer_byte,
	input wire logic xfer_end,
	input wire logic sense_done,
	output logic unit_check_status,
	output logic [7:0] sense_byte0,
	output logic noise_flag,
	output logic drive_status_a,
	output logic drive_status_b,
	output logic stop_transfer
);
	import tape_sense_pkg::*;

	logic [7:0] sense0_q, sense0_d;
	logic noise_q, noise_d;
	logic overrun_raw_q, overrun_raw_d;
	logic unit_check_q;
	logic [EQ_W-1:0] eq_detail_q;
	logic [DCK_W-1:0] dck_detail_q;
	logic [1:0] ctrl_q;
	logic [7:0] prev_cmd_q;
	logic ready_prev_q;
	logic burst_prev_q, bob_seen_q;
	logic first_byte_q;
	logic stop_xfer_q;
	logic status_a_q, status_b_q;
	logic command_reject_flag, intervention_set, channel_parity_check_flag;
	logic equipment_fault_flag, data_error_flag, service_overrun_flag, no_data_received_flag;
	logic noise_set, dck_base, ara_miss, gap_at_load_point, any_cause;

	function automatic logic cmd_defined(input logic [7:0] c);
		case (c)
			CMD_TEST_IO, CMD_WRITE, CMD_READ, CMD_READ_BACK, CMD_SENSE: cmd_defined = 1'b1;
			CMD_SNS_CTL_RESERVE, CMD_SNS_CTL_RELEASE, CMD_SNS_DRV_RESERVE: cmd_defined = 1'b1;
			CMD_SNS_DRV_RELEASE, CMD_UNCOND_RESERVE, CMD_NOP, CMD_SET_6250: cmd_defined = 1'b1;
			CMD_SET_1600, CMD_SET_800, CMD_DIAG_MODE, CMD_LOOP_WR, CMD_TRACK_ERR: cmd_defined = 1'b1;
			CMD_SET_DIAG, CMD_SENSE_TYPE, CMD_REWIND, CMD_SECURITY_ERASE: cmd_defined = 1'b1;
			CMD_SPACE_FILE, CMD_BACK_FILE, CMD_UNLOAD, CMD_ERASE_GAP: cmd_defined = 1'b1;
			CMD_WRITE_MARK, CMD_SPACE, CMD_BACK_SPACE, CMD_NORMAL_SPEED, CMD_HIGH_SPEED: cmd_defined = 1'b1;
			default: cmd_defined = 1'b0;
		endcase
	endfunction

	wire logic is_write_class = cmd_code == CMD_WRITE || cmd_code == CMD_WRITE_MARK || cmd_code == CMD_ERASE_GAP;
	wire logic is_ctl_resv = cmd_code == CMD_SNS_CTL_RESERVE || cmd_code == CMD_SNS_CTL_RELEASE;
	wire logic is_drv_resv = cmd_code == CMD_SNS_DRV_RESERVE || cmd_code == CMD_SNS_DRV_RELEASE ||
		cmd_code == CMD_UNCOND_RESERVE;
	wire logic hi_density = density == DENS_1600 || density == DENS_6250;

	// Event decode for the current cycle
	always_comb begin
		command_reject_flag = 1'b0;
		if (cmd_valid) begin
			if (is_write_class && drive_file_protect) begin
				command_reject_flag = 1'b1;
			end
			if (!cmd_defined(cmd_code)) begin
				command_reject_flag = 1'b1;
			end
			if (cmd_code == CMD_SECURITY_ERASE && !(cmd_chained && prev_cmd_q == CMD_ERASE_GAP)) begin
				command_reject_flag = 1'b1;
			end
			if (is_ctl_resv && (!ctrl_q[CTRL_DUAL_CH] || cmd_chained)) begin
				command_reject_flag = 1'b1;
			end
			if (is_drv_resv && cmd_chained) begin
				command_reject_flag = 1'b1;
			end
			if (ctrl_q[CTRL_COMPAT] && (is_drv_resv || cmd_code == CMD_SENSE_TYPE)) begin
				command_reject_flag = 1'b1;
			end
		end
		intervention_set = (cmd_valid && (!drive_present || !drive_online)) ||
			(op_active && ready_prev_q && !drive_ready);
		channel_parity_check_flag = (cmd_valid && cmd_parity_err) || data_parity_err || temp_hw_fault;
		ara_miss = burst_prev_q && !auto_read_amp_burst && !bob_seen_q;
		gap_at_load_point = ibg_detect && op_read && at_load_point;
		dck_base = (|dck_detail_in) || (ibg_detect && !gap_at_load_point);
		// Noise sources; the high density term uses data check without noise to avoid a loop
		noise_set = (dck_base && op_read && hi_density) ||
			(density == DENS_800 && ((op_read && noise_block_detect) || stop_delay_data)) ||
			erase_data_detect;
		data_error_flag = dck_base || (noise_set && !op_erase);
		equipment_fault_flag = (|eq_detail_in) || temp_hw_fault || (noise_set && op_erase) ||
			ara_miss || gap_at_load_point;
		service_overrun_flag = service_late && op_active && (op_read || op_write || op_loopback);
		no_data_received_flag = xfer_end && (op_write || op_loopback) && !first_byte_q && !xfer_byte;
		any_cause = command_reject_flag || intervention_set || channel_parity_check_flag ||
			equipment_fault_flag || data_error_flag || service_overrun_flag || no_data_received_flag || noise_set;
	end

	// Sticky flags: a set in the clearing cycle wins
	always_comb begin
		sense0_d = sense_done ? 8'h00 : sense0_q;
		noise_d = (sense_done ? 1'b0 : noise_q) || noise_set;
		overrun_raw_d = (sense_done ? 1'b0 : overrun_raw_q) || service_overrun_flag;
		sense0_d[SB0_REJECT] = sense0_d[SB0_REJECT] || command_reject_flag;
		sense0_d[SB0_INTERV] = sense0_d[SB0_INTERV] || intervention_set;
		sense0_d[SB0_PARITY] = sense0_d[SB0_PARITY] || channel_parity_check_flag;
		sense0_d[SB0_EQUIP] = sense0_d[SB0_EQUIP] || equipment_fault_flag;
		sense0_d[SB0_DATA] = sense0_d[SB0_DATA] || data_error_flag;
		// Raw overrun is kept so it reappears if data check alone is never set
		sense0_d[SB0_OVERRUN] = overrun_raw_d && !sense0_d[SB0_DATA];
		sense0_d[SB0_NODATA] = sense0_d[SB0_NODATA] || no_data_received_flag;
		sense0_d[7] = 1'b0;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sense0_q <= 8'h00;
			noise_q <= 1'b0;
			overrun_raw_q <= 1'b0;
			unit_check_q <= 1'b0;
		end else begin
			sense0_q <= sense0_d;
			noise_q <= noise_d;
			overrun_raw_q <= overrun_raw_d;
			unit_check_q <= |sense0_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			eq_detail_q <= '0;
			dck_detail_q <= '0;
		end else begin
			eq_detail_q <= (sense_done ? '0 : eq_detail_q) | eq_detail_in |
				(EQ_W'(temp_hw_fault) << EQ_MP_ERR);
			dck_detail_q <= (sense_done ? '0 : dck_detail_q) | dck_detail_in;
		end
	end

	// Command history and operation tracking
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_cmd_q <= CMD_TEST_IO;
			ready_prev_q <= 1'b0;
			burst_prev_q <= 1'b0;
			bob_seen_q <= 1'b0;
			first_byte_q <= 1'b0;
		end else begin
			if (cmd_valid) begin
				prev_cmd_q <= cmd_code;
			end
			ready_prev_q <= drive_ready;
			burst_prev_q <= auto_read_amp_burst;
			bob_seen_q <= auto_read_amp_burst && (bob_seen_q || block_begin_detect);
			if (xfer_end) begin
				first_byte_q <= 1'b0;
			end else if (xfer_byte) begin
				first_byte_q <= 1'b1;
			end
		end
	end

	// Transfer is cut off on overrun; the motion itself is left to end normally
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stop_xfer_q <= 1'b0;
		end else if (service_overrun_flag) begin
			stop_xfer_q <= 1'b1;
		end else if (!op_active) begin
			stop_xfer_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			status_a_q <= 1'b0;
			status_b_q <= 1'b0;
		end else begin
			status_a_q <= drive_present && drive_powered && drive_online && drive_ready;
			status_b_q <= drive_present && drive_powered && !(drive_online && drive_ready);
		end
	end

	// AXI4-Lite write channel: address and data accepted in either order
	logic awready_q, wready_q, bvalid_q, aw_got_q, w_got_q;
	logic [1:0] bresp_q;
	logic [ADDR_W-1:0] waddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	wire logic do_write = aw_got_q && w_got_q && !bvalid_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && awready_q) begin
				awready_q <= 1'b0;
				aw_got_q <= 1'b1;
				waddr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_got_q <= 1'b0;
			end else if (!aw_got_q && !bvalid_q) begin
				awready_q <= 1'b1;
			end
			if (s_axi_wvalid && wready_q) begin
				wready_q <= 1'b0;
				w_got_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_got_q <= 1'b0;
			end else if (!w_got_q && !bvalid_q) begin
				wready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			ctrl_q <= CTRL_RESET;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= (waddr_q[3:2] == ADDR_CTRL[3:2] || waddr_q[3:2] == ADDR_SENSE[3:2] ||
				waddr_q[3:2] == ADDR_EQ_DETAIL[3:2] || waddr_q[3:2] == ADDR_DCK_DETAIL[3:2]) ?
				RESP_OKAY : RESP_SLVERR;
			if (waddr_q[3:2] == ADDR_CTRL[3:2] && wstrb_q[0]) begin
				ctrl_q <= wdata_q[1:0];
			end
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// AXI4-Lite read channel; status registers are read only
	logic arready_q, rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			case (s_axi_araddr[3:2])
				ADDR_SENSE[3:2]: rdata_q <= {21'h0, status_b_q, status_a_q, noise_q, sense0_q};
				ADDR_EQ_DETAIL[3:2]: rdata_q <= {17'h0, eq_detail_q};
				ADDR_DCK_DETAIL[3:2]: rdata_q <= {14'h0, dck_detail_q};
				ADDR_CTRL[3:2]: rdata_q <= {30'h0, ctrl_q};
				default: begin
					rdata_q <= 32'h00000000;
					rresp_q <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign unit_check_status = unit_check_q;
	assign sense_byte0 = sense0_q;
	assign noise_flag = noise_q;
	assign drive_status_a = status_a_q;
	assign drive_status_b = status_b_q;
	assign stop_transfer = stop_xfer_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence short_burst_s;
		!auto_read_amp_burst ##1 (auto_read_amp_burst && !block_begin_detect)[*2] ##1 !auto_read_amp_burst;
	endsequence
	sequence empty_write_s;
		xfer_end && op_write && !first_byte_q && !xfer_byte;
	endsequence

	unit_check_a: assert property (sense_byte0 != 8'h00 |-> unit_check_status)
		else $error("unit check missing while sense byte set");
	protect_reject_a: assert property (cmd_valid && is_write_class && drive_file_protect |=> sense_byte0[SB0_REJECT])
		else $error("write to protected drive not rejected");
	undefined_cmd_a: assert property (cmd_valid && cmd_code == 8'hFF |=> sense_byte0[SB0_REJECT])
		else $error("undefined command not rejected");
	erase_chain_a: assert property (cmd_valid && cmd_code == CMD_SECURITY_ERASE && !cmd_chained |=> unit_check_status)
		else $error("unchained security erase not rejected");
	ctl_reserve_a: assert property (cmd_valid && is_ctl_resv && !ctrl_q[CTRL_DUAL_CH] |=> sense_byte0[SB0_REJECT])
		else $error("controller reserve without option not rejected");
	drive_reserve_a: assert property (cmd_valid && is_drv_resv && cmd_chained |=> sense_byte0[SB0_REJECT])
		else $error("chained reserve not rejected");
	compat_reject_a: assert property (cmd_valid && ctrl_q[CTRL_COMPAT] && cmd_code == CMD_SENSE_TYPE
		|=> sense_byte0[SB0_REJECT])
		else $error("compatibility mode command not rejected");
	interv_req_a: assert property (cmd_valid && !drive_present |=> sense_byte0[SB0_INTERV] && unit_check_status)
		else $error("absent drive not flagged");
	bus_parity_a: assert property (data_parity_err |=> sense_byte0[SB0_PARITY])
		else $error("channel parity error not flagged");
	equip_detail_a: assert property (eq_detail_in != '0 |=> sense_byte0[SB0_EQUIP] && eq_detail_q != '0)
		else $error("equipment detail not rolled up");
	burst_miss_a: assert property (short_burst_s |=> sense_byte0[SB0_EQUIP])
		else $error("missed block begin not flagged");
	data_detail_a: assert property (dck_detail_in != '0 |=> sense_byte0[SB0_DATA] && !sense_byte0[SB0_OVERRUN])
		else $error("data detail not rolled up");
	overrun_hide_a: assert property (sense_byte0[SB0_OVERRUN] |-> !sense_byte0[SB0_DATA])
		else $error("overrun shown with data check");
	overrun_stop_a: assert property (service_late && op_active && (op_read || op_write) ##1 op_active
		|-> stop_transfer)
		else $error("transfer not stopped on overrun");
	no_data_a: assert property (empty_write_s |=> sense_byte0[SB0_NODATA])
		else $error("empty write not flagged");
	converter_zero_a: assert property (!sense_byte0[7])
		else $error("converter bit not zero");
	erase_noise_a: assert property (erase_data_detect && op_erase |=> noise_flag && sense_byte0[SB0_EQUIP])
		else $error("erase noise not flagged");
	drive_ready_a: assert property (drive_present && drive_powered && drive_online && drive_ready
		|=> drive_status_a && !drive_status_b)
		else $error("ready drive encoded wrongly");
	sense_clear_a: assert property (sense_done && !any_cause |=> sense_byte0 == 8'h00 && !noise_flag)
		else $error("sense flags not cleared");
endmodule
`default_nettype wire

// ==== common/tape_sense_pkg.sv ====
// Constants for the tape controller sense and error logic.
// Assumes a single clock domain shared with the channel and drive interfaces.
package tape_sense_pkg;
	// Command codes
	localparam logic [7:0] CMD_TEST_IO = 8'h00;
	localparam logic [7:0] CMD_WRITE = 8'h01;
	localparam logic [7:0] CMD_READ = 8'h02;
	localparam logic [7:0] CMD_READ_BACK = 8'h0C;
	localparam logic [7:0] CMD_SENSE = 8'h04;
	localparam logic [7:0] CMD_SNS_CTL_RESERVE = 8'hF4;
	localparam logic [7:0] CMD_SNS_CTL_RELEASE = 8'hD4;
	localparam logic [7:0] CMD_SNS_DRV_RESERVE = 8'hB4;
	localparam logic [7:0] CMD_SNS_DRV_RELEASE = 8'h94;
	localparam logic [7:0] CMD_UNCOND_RESERVE = 8'h14;
	localparam logic [7:0] CMD_NOP = 8'h03;
	localparam logic [7:0] CMD_SET_6250 = 8'hD3;
	localparam logic [7:0] CMD_SET_1600 = 8'hC3;
	localparam logic [7:0] CMD_SET_800 = 8'hCB;
	localparam logic [7:0] CMD_DIAG_MODE = 8'h0B;
	localparam logic [7:0] CMD_LOOP_WR = 8'h8B;
	localparam logic [7:0] CMD_TRACK_ERR = 8'h1B;
	localparam logic [7:0] CMD_SET_DIAG = 8'h4B;
	localparam logic [7:0] CMD_SENSE_TYPE = 8'hE4;
	localparam logic [7:0] CMD_REWIND = 8'h07;
	localparam logic [7:0] CMD_SECURITY_ERASE = 8'h97;
	localparam logic [7:0] CMD_SPACE_FILE = 8'h3F;
	localparam logic [7:0] CMD_BACK_FILE = 8'h2F;
	localparam logic [7:0] CMD_UNLOAD = 8'h0F;
	localparam logic [7:0] CMD_ERASE_GAP = 8'h17;
	localparam logic [7:0] CMD_WRITE_MARK = 8'h1F;
	localparam logic [7:0] CMD_SPACE = 8'h37;
	localparam logic [7:0] CMD_BACK_SPACE = 8'h27;
	localparam logic [7:0] CMD_NORMAL_SPEED = 8'h83;
	localparam logic [7:0] CMD_HIGH_SPEED = 8'hE3;
	// Density codes
	localparam logic [1:0] DENS_800 = 2'h0;
	localparam logic [1:0] DENS_1600 = 2'h1;
	localparam logic [1:0] DENS_6250 = 2'h2;
	// First sense byte bit positions
	localparam int SB0_REJECT = 0;
	localparam int SB0_INTERV = 1;
	localparam int SB0_PARITY = 2;
	localparam int SB0_EQUIP = 3;
	localparam int SB0_DATA = 4;
	localparam int SB0_OVERRUN = 5;
	localparam int SB0_NODATA = 6;
	// Detail flag vectors
	localparam int EQ_W = 15;
	localparam int DCK_W = 18;
	localparam int EQ_MP_ERR = 0;
	localparam int EQ_REJECT_DRIVE = 1;
	// Register map
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_SENSE = 4'h0;
	localparam logic [3:0] ADDR_EQ_DETAIL = 4'h4;
	localparam logic [3:0] ADDR_DCK_DETAIL = 4'h8;
	localparam logic [3:0] ADDR_CTRL = 4'hC;
	localparam int CTRL_COMPAT = 0;
	localparam int CTRL_DUAL_CH = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== verification/tape_drive_model.sv ====
// Behavioural model of the selected tape drive's status lines.
// Assumes the bench picks the drive condition: 0 absent, 1 powered offline, 2 ready.
`timescale 1ns/10ps
`default_nettype none
module tape_drive_model (
	input wire logic [1:0] mode,
	input wire logic protect,
	output logic present,
	output logic powered,
	output logic online,
	output logic ready,
	output logic file_protect
);
	// An absent drive reports nothing powered, so a lost drive looks like a dead one
	assign present = mode != 2'h0;
	assign powered = mode != 2'h0;
	assign online = mode == 2'h2;
	assign ready = mode == 2'h2;
	assign file_protect = protect;
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the tape sense and error logic.
// Assumes the package constants and a 20 MHz clock; all stimulus by NBA, at the rising edge or 1 ns after it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import tape_sense_pkg::*;
	logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmd_valid, cmd_chained, cmd_parity_err;
	logic data_parity_err, temp_hw_fault, drive_present, drive_powered, drive_online, drive_ready;
	logic drive_file_protect, op_active, op_read, op_write, op_loopback, op_erase, at_load_point;
	logic noise_block_detect, stop_delay_data, erase_data_detect, ibg_detect, auto_read_amp_burst;
	logic block_begin_detect, service_late, xfer_byte, xfer_end, sense_done, unit_check_status, noise_flag;
	logic drive_status_a, drive_status_b, stop_transfer, protect;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, density, mode;
	logic [7:0] cmd_code, sense_byte0;
	logic [EQ_W-1:0] eq_detail_in;
	logic [DCK_W-1:0] dck_detail_in;
	int miscompares = 0;
	int samples_checked = 0;
	tape_ctrl_sense_error_logic dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmd_valid,
		.cmd_code, .cmd_chained, .cmd_parity_err, .data_parity_err, .temp_hw_fault, .drive_present, .drive_powered,
		.drive_online, .drive_ready, .drive_file_protect, .op_active, .op_read, .op_write, .op_loopback, .op_erase,
		.density, .at_load_point, .noise_block_detect, .stop_delay_data, .erase_data_detect, .eq_detail_in,
		.dck_detail_in, .ibg_detect, .auto_read_amp_burst, .block_begin_detect, .service_late, .xfer_byte,
		.xfer_end, .sense_done, .unit_check_status, .sense_byte0, .noise_flag, .drive_status_a, .drive_status_b,
		.stop_transfer);
	tape_drive_model drv (.mode(mode), .protect(protect), .present(drive_present), .powered(drive_powered),
		.online(drive_online), .ready(drive_ready), .file_protect(drive_file_protect));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic hang(input bit done);
		if (!done) begin
			miscompares++;
			tally_and_finish();
		end
	endtask
	// Bus master: address and data offered together, each dropped once taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		int n;
		bit aw, w, b;
		{n, aw, w, b} = '0;
		@(posedge clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_wstrb} <= {3'h7, 4'hF};
		while (!b && n < 50) begin
			@(posedge clk);
			n++;
			if (!aw && s_axi_awready) begin aw = 1; s_axi_awvalid <= 1'b0; end
			if (!w && s_axi_wready) begin w = 1; s_axi_wvalid <= 1'b0; end
			if (aw && w && s_axi_bvalid) begin b = 1; s_axi_bready <= 1'b0; chk("bresp", RESP_OKAY, s_axi_bresp); end
		end
		hang(b);
	endtask
	task automatic axr(input logic [3:0] a);
		int n;
		bit ad, r;
		{n, ad, r} = '0;
		@(posedge clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (!r && n < 50) begin
			@(posedge clk);
			n++;
			if (!ad && s_axi_arready) begin ad = 1; s_axi_arvalid <= 1'b0; end
			else if (ad && s_axi_rvalid) begin r = 1; rd = s_axi_rdata; s_axi_rready <= 1'b0; end
		end
		hang(r);
		chk("rresp", RESP_OKAY, s_axi_rresp);
	endtask
	task automatic cmd(input logic [7:0] c, input logic ch);
		@(posedge clk);
		{cmd_valid, cmd_code, cmd_chained} <= {1'b1, c, ch};
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1;
	endtask
	task automatic ev(input int k, input int b);
		@(posedge clk);
		case (k)
			0: eq_detail_in[b] <= 1'b1;
			1: dck_detail_in[b] <= 1'b1;
			2: service_late <= 1'b1;
			3: xfer_end <= 1'b1;
			4: erase_data_detect <= 1'b1;
			5: xfer_byte <= 1'b1;
			6: data_parity_err <= 1'b1;
			7: temp_hw_fault <= 1'b1;
			8: noise_block_detect <= 1'b1;
			9: stop_delay_data <= 1'b1;
			10: ibg_detect <= 1'b1;
			default: block_begin_detect <= 1'b1;
		endcase
		@(posedge clk);
		{eq_detail_in, dck_detail_in} <= '0;
		{service_late, xfer_end, erase_data_detect, xfer_byte, data_parity_err, temp_hw_fault} <= '0;
		{noise_block_detect, stop_delay_data, ibg_detect, block_begin_detect} <= '0;
		#1;
	endtask
	// Checks the first sense byte and the unit check it implies, then clears it by a sense read
	task automatic sb(input logic [7:0] exp);
		chk("sense_byte0", {24'h0, exp}, {24'h0, sense_byte0});
		chk("unit_check", {31'h0, exp != 8'h00}, {31'h0, unit_check_status});
		@(posedge clk);
		sense_done <= 1'b1;
		@(posedge clk);
		sense_done <= 1'b0;
		#1;
		chk("cleared", 32'h0, {23'h0, noise_flag, sense_byte0});
	endtask
	task automatic t_regs;
		axr(ADDR_CTRL);
		chk("ctrl reset", 32'h0, rd);
		axw(ADDR_SENSE, 32'hFFFFFFFF);
		axr(ADDR_SENSE);
		chk("sense ro", 32'h200, rd);
		$display("test regs done");
	endtask
	task automatic t_reject;
		cmd(8'hFF, 1'b0);
		sb(8'h01);
		cmd(CMD_SECURITY_ERASE, 1'b0);
		sb(8'h01);
		cmd(CMD_ERASE_GAP, 1'b0);
		cmd(CMD_SECURITY_ERASE, 1'b1);
		sb(8'h00);
		cmd(CMD_SNS_CTL_RESERVE, 1'b0);
		sb(8'h01);
		cmd(CMD_SNS_DRV_RELEASE, 1'b1);
		sb(8'h01);
		axw(ADDR_CTRL, 32'h2);
		cmd(CMD_SNS_CTL_RELEASE, 1'b0);
		sb(8'h00);
		cmd(CMD_SNS_CTL_RESERVE, 1'b1);
		sb(8'h01);
		axw(ADDR_CTRL, 32'h3);
		axr(ADDR_CTRL);
		chk("ctrl rw", 32'h3, rd);
		cmd(CMD_SNS_DRV_RESERVE, 1'b0);
		sb(8'h01);
		cmd(CMD_UNCOND_RESERVE, 1'b0);
		sb(8'h01);
		cmd(CMD_SENSE_TYPE, 1'b0);
		sb(8'h01);
		axw(ADDR_CTRL, 32'h0);
		protect <= 1'b1;
		cmd(CMD_WRITE_MARK, 1'b0);
		sb(8'h01);
		$display("test reject done");
	endtask
	task automatic t_events;
		protect <= 1'b0;
		ev(6, 0);
		sb(8'h04);
		ev(7, 0);
		sb(8'h0C);
		ev(0, 1);
		sb(8'h08);
		ev(0, 9);
		sb(8'h08);
		ev(1, 17);
		sb(8'h10);
		{op_active, op_write} <= 2'h3;
		ev(2, 0);
		chk("stop", 32'h1, {31'h0, stop_transfer});
		sb(8'h20);
		ev(3, 0);
		sb(8'h40);
		ev(2, 0);
		ev(1, 0);
		sb(8'h10);
		{op_active, op_write, op_loopback} <= 3'h1;
		ev(5, 0);
		ev(3, 0);
		sb(8'h00);
		{op_active, op_loopback, op_erase} <= 3'h5;
		ev(4, 0);
		chk("noise erase", 32'h1, {31'h0, noise_flag});
		sb(8'h08);
		{op_erase, op_read, density} <= {2'h1, DENS_1600};
		ev(1, 3);
		chk("noise dense", 32'h1, {31'h0, noise_flag});
		sb(8'h10);
		density <= DENS_800;
		ev(8, 0);
		chk("noise block", 32'h1, {31'h0, noise_flag});
		sb(8'h10);
		at_load_point <= 1'b1;
		ev(10, 0);
		sb(8'h08);
		auto_read_amp_burst <= 1'b1;
		ev(9, 0);
		auto_read_amp_burst <= 1'b0;
		ev(11, 0);
		sb(8'h18);
		$display("test events done");
	endtask
	task automatic t_drive;
		mode <= 2'h1;
		repeat (2) @(posedge clk);
		#1;
		chk("status offline", 32'h2, {30'h0, drive_status_b, drive_status_a});
		mode <= 2'h0;
		repeat (2) @(posedge clk);
		#1;
		chk("status absent", 32'h0, {30'h0, drive_status_b, drive_status_a});
		cmd(CMD_NOP, 1'b0);
		{mode, op_active} <= 3'h5;
		repeat (2) @(posedge clk);
		mode <= 2'h1;
		repeat (2) @(posedge clk);
		#1;
		sb(8'h02);
		$display("test drive done");
	endtask
	initial begin
		{arst_n, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, density, cmd_code, eq_detail_in} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cmd_valid, cmd_chained} = '0;
		{cmd_parity_err, data_parity_err, temp_hw_fault, op_active, op_read, op_write, op_loopback} = '0;
		{op_erase, at_load_point, noise_block_detect, stop_delay_data, erase_data_detect, ibg_detect} = '0;
		{auto_read_amp_burst, block_begin_detect, service_late, xfer_byte, xfer_end, sense_done} = '0;
		{dck_detail_in, protect} = '0;
		mode = 2'h2;
		repeat (8) @(posedge clk);
		arst_n <= 1'b1;
		t_regs();
		t_reject();
		t_events();
		t_drive();
		tally_and_finish();
	end
endmodule
`default_nettype wire
